// File: hw/measure_counter_regs.vh
// register offsets, fields and timing constants of the measurement counter
`ifndef MEASURE_COUNTER_REGS_VH
`define MEASURE_COUNTER_REGS_VH

// ----------------------------------------
// register offsets (8-bit address)
// ----------------------------------------
`define ADDR_CTRL_ONE      8'h00
`define ADDR_CTRL_TWO      8'h01
`define ADDR_STATUS        8'h02
`define ADDR_COUNT_LO      8'h03
`define ADDR_COUNT_HI      8'h04
`define ADDR_GATE_PERIOD   8'h05
`define ADDR_IRQ_STATUS    8'h06

// ----------------------------------------
// counter_control_one fields
// ----------------------------------------
`define C1_START_LSB       0
`define C1_MODE_BIT        2
`define C1_SRC_LSB         3
`define C1_CLEAR_BIT       7
`define START_STOP         2'h0
`define START_RUN          2'h2
`define MODE_PULSE         1'b0
`define MODE_FREQ          1'b1
`define SRC_EXTERNAL       3'h7

// ----------------------------------------
// counter_control_two fields
// ----------------------------------------
`define C2_TICK_LSB        2
`define C2_EDGE_BIT        4
`define C2_GATE_LSB        5
`define GATE_PIN           2'h0
`define GATE_INTERNAL      2'h1
`define EDGE_FALL          1'b0
`define EDGE_BOTH          1'b1

// ----------------------------------------
// status fields and widths
// ----------------------------------------
`define ST_WINDOW_BIT      7
`define ST_OVF_BIT         6
`define COUNT_W            18
`define COUNT_MAX          18'h3ffff
`define PERIOD_BASE        5'h10

// ----------------------------------------
// divider: taps for source clock and gate tick
// ----------------------------------------
`define DIV_W              15
`define GATE_TICK_TAP0     12
`define SRC_TAP0           4'h0
`define SRC_TAP1           4'h3
`define SRC_TAP2           4'h7
`define SRC_TAP3           4'hb
`define SRC_TAP4           4'hd

`endif

// File: hw/edge_detect.v
// registered edge detector for one level
`timescale 1ns/10ps
module edge_detect (
  // clock and reset
  input  wire clock,
  input  wire resetn,
  // level in
  input  wire level,
  // edge pulses out
  output wire rise,
  output wire fall
);

  reg level_r;

  always @(posedge clock) begin
    if (!resetn) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level;
    end
  end

  assign rise = level & ~level_r;
  assign fall = ~level & level_r;

endmodule // edge_detect

// File: hw/gate_generator.v
// internal window gate: alternating high and low periods in ticks
`timescale 1ns/10ps
`include "measure_counter_regs.vh"
module gate_generator (
  // clock and reset
  input  wire       clock,
  input  wire       resetn,
  // control
  input  wire       run,
  input  wire       tick,
  input  wire [3:0] high_field,
  input  wire [3:0] low_field,
  // gate out
  output reg        gate_r
);

  localparam ST_IDLE = 2'h0;
  localparam ST_HIGH = 2'h1;
  localparam ST_LOW  = 2'h2;

  reg [1:0] state_r;
  reg [4:0] left_r;

  always @(posedge clock) begin
    if (!resetn) begin
      state_r    <= ST_IDLE;
      left_r     <= 5'h00;
      gate_r     <= 1'b0;
    end else if (!run) begin
      state_r <= ST_IDLE;
      gate_r  <= 1'b0;
    end else if (tick) begin
      case (state_r)
        ST_IDLE: begin
          state_r <= ST_HIGH;
          gate_r  <= 1'b1;
          left_r  <= `PERIOD_BASE - {1'b0, high_field} - 5'h01;
        end
        ST_HIGH: begin
          if (left_r == 5'h00) begin
            state_r    <= ST_LOW;
            gate_r     <= 1'b0;
            left_r     <= `PERIOD_BASE - {1'b0, low_field} - 5'h01;
          end else begin
            left_r <= left_r - 5'h01;
          end
        end
        ST_LOW: begin
          if (left_r == 5'h00) begin
            state_r <= ST_HIGH;
            gate_r  <= 1'b1;
            left_r  <= `PERIOD_BASE - {1'b0, high_field} - 5'h01;
          end else begin
            left_r <= left_r - 5'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          gate_r  <= 1'b0;
        end
      endcase
    end
  end

endmodule // gate_generator

// File: hw/measure_counter.v
// measurement counter: pulse width and frequency modes
//
// Functional notes
// - pulse mode counts falling edges of window AND clock
// - pulse mode irq on falling or both edges
// - uncleared counter resumes from held value
// - wrap to zero sets overflow flag
// - overflow flag held until counter clear
// - stop while window high raises irq
// - both-edge start with window high raises irq
// - window flag meaningless in pulse mode
// - window falling during clock high adds one
// - frequency mode counts count pin edges gated
// - gate select 00 uses external gate pin
// - gate select 01 internal gate, 10 reserved
// - frequency irq on gate falling or both edges
// - window flag shows gate state in frequency
// - flag zero stopped or low, one counting high
// - internal gate alternates high and low periods
// - each period lasts 16 minus field ticks
// - tick select 2^12, 2^13, 2^14; 11 reserved
// - first gate period may start one tick late
// - low period change takes effect next low
// - gate falling with count pin high adds one
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "measure_counter_regs.vh"
module measure_counter (
  // clock and reset
  input  wire       clock,
  input  wire       resetn,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata_r,
  // pins
  input  wire       count_input_pin,
  input  wire       external_gate_pin,
  // event out
  output reg        measure_irq
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [1:0]           start_r;
  reg                 mode_r;
  reg [2:0]           src_r;
  reg [1:0]           tick_sel_r;
  reg                 edge_sel_r;
  reg [1:0]           gate_sel_r;
  reg [7:0]           period_r;
  reg [`COUNT_W-1:0]  count_r;
  reg [`COUNT_W-1:0]  count_nxt;
  reg                 ovf_r;
  reg                 ovf_nxt;
  reg                 irq_seen_r;
  reg [`DIV_W-1:0]    div_r;
  reg                 src_clk_r;
  reg                 tick_r;
  reg                 and_prev_r;

  wire running  = (start_r == `START_RUN);
  wire wr_c1    = wr && (addr == `ADDR_CTRL_ONE);
  wire wr_c2    = wr && (addr == `ADDR_CTRL_TWO);
  wire clear_wr = wr_c1 && wdata[`C1_CLEAR_BIT];
  wire [1:0] new_start = wdata[`C1_START_LSB+1:`C1_START_LSB];

  // ----------------------------------------
  // system divider and source clock select
  // ----------------------------------------
  reg [3:0] src_tap;
  reg       tick_hit;
  always @* begin
    case (src_r)
      3'h0:    src_tap = `SRC_TAP4;
      3'h1:    src_tap = `SRC_TAP3;
      3'h2:    src_tap = `SRC_TAP2;
      3'h3:    src_tap = `SRC_TAP1;
      default: src_tap = `SRC_TAP0;
    endcase
    case (tick_sel_r)
      2'h0:    tick_hit = &div_r[`GATE_TICK_TAP0-1:0];
      2'h1:    tick_hit = &div_r[`GATE_TICK_TAP0:0];
      default: tick_hit = &div_r[`GATE_TICK_TAP0+1:0];
    endcase
  end

  always @(posedge clock) begin
    if (!resetn) begin
      div_r     <= {`DIV_W{1'b0}};
      src_clk_r <= 1'b0;
      tick_r    <= 1'b0;
    end else begin
      div_r     <= div_r + {{(`DIV_W-1){1'b0}}, 1'b1};
      // source clock level; tap 0 toggles every cycle
      src_clk_r <= div_r[src_tap];
      tick_r    <= tick_hit;
    end
  end

  // ----------------------------------------
  // window gate selection
  // ----------------------------------------
  wire int_gate;
  gate_generator u_gate (
    .clock      (clock),
    .resetn     (resetn),
    .run        (running && mode_r == `MODE_FREQ && gate_sel_r == `GATE_INTERNAL),
    .tick       (tick_r),
    .high_field (period_r[3:0]),
    .low_field  (period_r[7:4]),
    .gate_r     (int_gate)
  );

  wire freq_gate = (gate_sel_r == `GATE_PIN)      ? external_gate_pin :
                   (gate_sel_r == `GATE_INTERNAL) ? int_gate : 1'b0;
  // window seen by the irq logic; gated off while stopped
  wire window = running && ((mode_r == `MODE_PULSE) ? count_input_pin : freq_gate);

  wire win_rise;
  wire win_fall;
  edge_detect u_win (
    .clock  (clock),
    .resetn (resetn),
    .level  (window),
    .rise   (win_rise),
    .fall   (win_fall)
  );

  // ----------------------------------------
  // count source: falling edge of the AND
  // ----------------------------------------
  // window AND source clock
  // count pin AND gate; fall out of the AND
  wire and_now = running && ((mode_r == `MODE_PULSE) ? (count_input_pin & src_clk_r)
                                                     : (count_input_pin & freq_gate));
  wire inc = and_prev_r & ~and_now;

  always @* begin
    count_nxt = count_r;
    ovf_nxt   = ovf_r;
    if (clear_wr) begin
      count_nxt = {`COUNT_W{1'b0}};
      ovf_nxt   = 1'b0;
    end else if (inc) begin
      count_nxt = count_r + {{(`COUNT_W-1){1'b0}}, 1'b1};
      if (count_r == `COUNT_MAX) begin
        ovf_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // irq event: edges, stop and start writes
  // ----------------------------------------
  wire pulse_win_high = (mode_r == `MODE_PULSE) && count_input_pin;
  wire stop_evt  = wr_c1 && running && (new_start == `START_STOP) && pulse_win_high;
  wire start_evt = wr_c1 && !running && (new_start == `START_RUN) &&
                   (wdata[`C1_MODE_BIT] == `MODE_PULSE) && count_input_pin &&
                   (edge_sel_r == `EDGE_BOTH);
  wire edge_evt  = win_fall || (win_rise && edge_sel_r == `EDGE_BOTH);
  // start or stop write swallows the edge it causes, so one irq only
  wire irq_evt   = stop_evt || start_evt || (edge_evt && !irq_seen_r);

  always @(posedge clock) begin
    if (!resetn) begin
      start_r     <= `START_STOP;
      mode_r      <= `MODE_PULSE;
      src_r       <= 3'h0;
      tick_sel_r  <= 2'h0;
      edge_sel_r  <= `EDGE_FALL;
      gate_sel_r  <= `GATE_PIN;
      period_r    <= 8'h00;
      count_r     <= {`COUNT_W{1'b0}};
      ovf_r       <= 1'b0;
      and_prev_r  <= 1'b0;
      irq_seen_r  <= 1'b0;
      measure_irq <= 1'b0;
      rdata_r     <= 8'h00;
    end else begin
      count_r     <= count_nxt;
      ovf_r       <= ovf_nxt;
      and_prev_r  <= and_now;
      irq_seen_r  <= stop_evt || start_evt;
      measure_irq <= irq_evt;
      if (wr_c1) begin
        start_r <= new_start;
        mode_r  <= wdata[`C1_MODE_BIT];
        src_r   <= wdata[`C1_SRC_LSB+2:`C1_SRC_LSB];
      end
      if (wr_c2) begin
        tick_sel_r <= wdata[`C2_TICK_LSB+1:`C2_TICK_LSB];
        edge_sel_r <= wdata[`C2_EDGE_BIT];
        gate_sel_r <= wdata[`C2_GATE_LSB+1:`C2_GATE_LSB];
      end
      // low field sampled at next low start
      if (wr && addr == `ADDR_GATE_PERIOD) begin
        period_r <= wdata;
      end
      // read data valid one cycle after strobe
      if (rd) begin
        case (addr)
          `ADDR_CTRL_ONE:    rdata_r <= {2'h0, src_r, mode_r, start_r};
          `ADDR_CTRL_TWO:    rdata_r <= {1'b0, gate_sel_r, edge_sel_r, tick_sel_r, 2'h2};
          // window flag; pulse mode reads zero
          `ADDR_STATUS:      rdata_r <= {(mode_r == `MODE_FREQ) && window, ovf_r, 6'h00};
          `ADDR_COUNT_LO:    rdata_r <= count_r[7:0];
          `ADDR_COUNT_HI:    rdata_r <= count_r[15:8];
          `ADDR_GATE_PERIOD: rdata_r <= period_r;
          `ADDR_IRQ_STATUS:  rdata_r <= {6'h00, count_r[17:16]};
          default:           rdata_r <= 8'h00;
        endcase
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

endmodule // measure_counter

// File: bench/measure_counter_properties.sv
// port checker for the measurement counter
`timescale 1ns/10ps
`include "measure_counter_regs.vh"
module measure_counter_properties (
  // clock and reset
  input wire       clock,
  input wire       resetn,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata_r,
  // pins and event
  input wire       count_input_pin,
  input wire       external_gate_pin,
  input wire       measure_irq
);
  reg  [7:0] c1_r;
  reg  [7:0] c2_r;
  wire       run = c1_r[1:0] == `START_RUN;
  wire       frq = c1_r[`C1_MODE_BIT];
  wire       two = c2_r[`C2_EDGE_BIT];
  wire       win = frq ? external_gate_pin : count_input_pin;
  wire       sel = !frq || c2_r[6:5] == `GATE_PIN;
  wire       w1  = wr && addr == `ADDR_CTRL_ONE;
  wire       stp = w1 && wdata[1:0] == `START_STOP;
  // shadow controls, so edges are judged in the live mode
  always @(posedge clock) begin
    if (!resetn) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
    end else begin
      if (w1)
        c1_r <= wdata;
      if (wr && addr == `ADDR_CTRL_TWO)
        c2_r <= wdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_fall_irq: assert property (run && sel && $fell(win) |-> ##[1:4] measure_irq)
    else $error("no irq after window fall");
  a_rise_irq: assert property (run && sel && two && $rose(win) |-> ##[1:4] measure_irq)
    else $error("no irq after window rise");
  a_irq_single: assert property (measure_irq |=> !measure_irq)
    else $error("irq longer than one cycle");
  a_stop_irq: assert property (stp && run && !frq && count_input_pin |-> ##[1:3] measure_irq)
    else $error("no irq on stop with window high");
  a_start_irq: assert property (w1 && wdata[1:0] == `START_RUN && !wdata[`C1_MODE_BIT] && two
    && !run && count_input_pin |-> ##[1:3] measure_irq)
    else $error("no irq on start with window high");
  a_flag_stop: assert property (rd && addr == `ADDR_STATUS && !run && !$past(run)
    |=> !rdata_r[`ST_WINDOW_BIT])
    else $error("window flag set while stopped");
  a_status_pad: assert property (rd && addr == `ADDR_STATUS |=> rdata_r[5:0] == 6'h00)
    else $error("status low bits not zero");
  a_count_width: assert property (rd && addr == `ADDR_IRQ_STATUS |=> rdata_r[7:2] == 6'h00)
    else $error("count wider than 18 bits");
  a_clear_count: assert property (stp && wdata[`C1_CLEAR_BIT] ##[1:2] rd
    && addr == `ADDR_COUNT_LO |=> rdata_r == 8'h00)
    else $error("count not zero after clear");
  a_clear_ovf: assert property (stp && wdata[`C1_CLEAR_BIT] ##[1:2] rd
    && addr == `ADDR_STATUS |=> !rdata_r[`ST_OVF_BIT])
    else $error("overflow not zero after clear");
  c_freq_irq: cover property (frq && measure_irq);
  c_flag_high: cover property (rd && addr == `ADDR_STATUS ##1 rdata_r[`ST_WINDOW_BIT]);
  c_stop_irq: cover property (stp && !frq && count_input_pin);
endmodule // measure_counter_properties

bind measure_counter measure_counter_properties chk (
  .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_r(rdata_r), .count_input_pin(count_input_pin),
  .external_gate_pin(external_gate_pin), .measure_irq(measure_irq));

// File: bench/pulse_source.sv
// external pulse source on the count pin and the gate pin
`timescale 1ns/10ps
module pulse_source (
  // clock
  input  wire  clock,
  // pins
  output logic count_input_pin,
  output logic external_gate_pin
);
  initial begin
    count_input_pin   = 1'b0;
    external_gate_pin = 1'b0;
  end
  // gate around n pulses; with n zero, hold keeps the pin high as the gate falls
  task automatic window(input int n, input logic hold);
    @(posedge clock);
    external_gate_pin <= 1'b1;
    count_input_pin   <= hold;
    repeat (4) @(posedge clock);
    repeat (n) begin
      count_input_pin <= 1'b1;
      repeat (2) @(posedge clock);
      count_input_pin <= 1'b0;
      repeat (2) @(posedge clock);
    end
    external_gate_pin <= 1'b0;
    repeat (4) @(posedge clock);
    count_input_pin <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // window level on the count pin, held len cycles
  task automatic level(input logic v, input int len);
    @(posedge clock);
    count_input_pin <= v;
    repeat (len) @(posedge clock);
  endtask
endmodule // pulse_source

// File: bench/measure_counter_tb.sv
// self-checking bench for the measurement counter
`timescale 1ns/10ps
`include "measure_counter_regs.vh"
module measure_counter_tb;
  logic        clock;
  logic        resetn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata_r;
  logic        count_input_pin;
  logic        external_gate_pin;
  logic        measure_irq;
  logic [17:0] cnt;
  logic [7:0]  v;
  int          miscompares = 0;
  int          checks_done = 0;
  int          irqs = 0;
  int          n;
  int          gap;
  measure_counter dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_r(rdata_r), .count_input_pin(count_input_pin),
    .external_gate_pin(external_gate_pin), .measure_irq(measure_irq));
  pulse_source src (.clock(clock), .count_input_pin(count_input_pin),
    .external_gate_pin(external_gate_pin));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (measure_irq === 1'b1)
      irqs <= irqs + 1;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata_r;
  endtask
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // three reads, taken with the pins idle so the count is steady
  task automatic get_count();
    read(`ADDR_COUNT_LO, cnt[7:0]);
    read(`ADDR_COUNT_HI, cnt[15:8]);
    read(`ADDR_IRQ_STATUS, v);
    cnt[17:16] = v[1:0];
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded poll on the falling edge, where the pulse has settled
  task automatic wait_irq();
    n = 0;
    @(negedge clock);
    while (measure_irq !== 1'b1 && n < 30000) begin
      @(negedge clock);
      n++;
    end
    if (n == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  initial begin
    resetn = 1'b0;
    addr   = 8'h00;
    wdata  = 8'h00;
    wr     = 1'b0;
    rd     = 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    read(`ADDR_STATUS, v);
    check(v, 8'h00);
    write(`ADDR_CTRL_TWO, 8'h02);
    write(`ADDR_CTRL_ONE, 8'h80);
    write(`ADDR_CTRL_ONE, 8'h3e);
    fork
      src.window(5, 1'b0);
      begin
        repeat (10) @(posedge clock);
        read(`ADDR_STATUS, v);
        check(v, 8'h80);
      end
    join
    get_count();
    check(cnt, 18'h5);
    check(irqs, 1);
    src.window(3, 1'b0);
    get_count();
    check(cnt, 18'h8);
    write(`ADDR_CTRL_ONE, 8'hbc);
    get_count();
    check(cnt, 18'h0);
    write(`ADDR_CTRL_ONE, 8'h3e);
    src.window(0, 1'b1);
    get_count();
    check(cnt, 18'h1);
    write(`ADDR_CTRL_ONE, 8'h3c);
    write(`ADDR_CTRL_TWO, 8'h12);
    write(`ADDR_CTRL_ONE, 8'h3e);
    src.window(2, 1'b0);
    get_count();
    check(cnt, 18'h3);
    check(irqs, 5);
    write(`ADDR_CTRL_ONE, 8'h3c);
    write(`ADDR_CTRL_TWO, 8'h42);
    write(`ADDR_CTRL_ONE, 8'h3e);
    src.window(4, 1'b0);
    get_count();
    check(cnt, 18'h3);
    check(irqs, 5);
    // pulse width, source clock at half rate, both edges
    write(`ADDR_CTRL_ONE, 8'ha0);
    write(`ADDR_CTRL_TWO, 8'h12);
    write(`ADDR_CTRL_ONE, 8'h22);
    read(`ADDR_CTRL_ONE, v);
    check(v, 8'h22);
    read(`ADDR_CTRL_TWO, v);
    check(v, 8'h12);
    src.level(1'b1, 40);
    src.level(1'b0, 8);
    get_count();
    check(cnt >= 18'd19 && cnt <= 18'd21, 18'h1);
    check(irqs, 7);
    write(`ADDR_CTRL_ONE, 8'h20);
    src.level(1'b1, 4);
    write(`ADDR_CTRL_ONE, 8'h22);
    repeat (10) @(posedge clock);
    check(irqs, 8);
    write(`ADDR_CTRL_ONE, 8'h20);
    src.level(1'b0, 10);
    check(irqs, 9);
    // internal gate: high 2 ticks, low 1 tick; sum of both gaps is order-free
    write(`ADDR_CTRL_ONE, 8'hbc);
    write(`ADDR_GATE_PERIOD, 8'hfe);
    read(`ADDR_GATE_PERIOD, v);
    check(v, 8'hfe);
    write(`ADDR_CTRL_TWO, 8'h32);
    write(`ADDR_CTRL_ONE, 8'h3e);
    wait_irq();
    wait_irq();
    gap = n + 1;
    wait_irq();
    check(gap + n + 1, 18'd12288);
    write(`ADDR_CTRL_ONE, 8'hbc);
    tally_and_finish();
  end
endmodule // measure_counter_tb
